/* File: fpc_pkg.sv */
package fpc_pkg;
	// ---------------------------------------------------------------
	// bus geometry
	// ---------------------------------------------------------------
	localparam int FPC_ADDR_W = 26;
	localparam int FPC_DATA_W = 16;
	localparam int FPC_REG_AW = 4;
	localparam int FPC_SEC_LSB = 16; // sector select from top line down to this bit

	// ---------------------------------------------------------------
	// command addresses and codes
	// ---------------------------------------------------------------
	localparam logic [25:0] FPC_A16_UNLK1 = 26'h0000555;
	localparam logic [25:0] FPC_A16_UNLK2 = 26'h00002aa;
	localparam logic [25:0] FPC_A8_UNLK1 = 26'h0000aaa;
	localparam logic [25:0] FPC_A8_UNLK2 = 26'h0000555;
	localparam logic [25:0] FPC_A_ZERO = 26'h0000000;
	localparam logic [25:0] FPC_A_LOCKWORD = 26'h0000077;
	localparam logic [25:0] FPC_A_AS_PROT = 26'h0000004;
	localparam logic [7:0] FPC_D_AA = 8'haa;
	localparam logic [7:0] FPC_D_55 = 8'h55;
	localparam logic [7:0] FPC_C_PPB = 8'hc0;
	localparam logic [7:0] FPC_C_FREEZE = 8'h50;
	localparam logic [7:0] FPC_C_DYB = 8'he0;
	localparam logic [7:0] FPC_C_LOCK = 8'h40;
	localparam logic [7:0] FPC_C_PWD = 8'h60;
	localparam logic [7:0] FPC_C_PROG = 8'ha0;
	localparam logic [7:0] FPC_C_EXIT1 = 8'h90;
	localparam logic [7:0] FPC_C_EXIT2 = 8'h00;
	localparam logic [7:0] FPC_C_ERASE = 8'h80;
	localparam logic [7:0] FPC_C_ERS_SEC = 8'h30;
	localparam logic [7:0] FPC_C_ERS_CHIP = 8'h10;
	localparam logic [7:0] FPC_C_UNL1 = 8'h25;
	localparam logic [7:0] FPC_C_UNL2 = 8'h03;
	localparam logic [7:0] FPC_C_CONFIRM = 8'h29;
	localparam logic [7:0] FPC_C_SUSPEND = 8'hb0;
	localparam logic [7:0] FPC_C_RESUME = 8'h30;
	localparam logic [7:0] FPC_C_RESET = 8'hf0;
	localparam logic [7:0] FPC_C_AUTOSEL = 8'h90;
	localparam logic [15:0] FPC_D_PROTECT = 16'h0000;
	localparam logic [15:0] FPC_D_UNPROTECT = 16'h0001;
	localparam logic [15:0] FPC_LOCK_RST = 16'hffff;
	localparam int FPC_LK_PERS = 1;
	localparam int FPC_LK_PWD = 2;

	// ---------------------------------------------------------------
	// host register map (word index)
	// ---------------------------------------------------------------
	localparam logic [3:0] FPC_R_CMD = 4'h0;
	localparam logic [3:0] FPC_R_ADDR = 4'h1;
	localparam logic [3:0] FPC_R_DATA = 4'h2;
	localparam logic [3:0] FPC_R_STAT = 4'h3;
	localparam logic [3:0] FPC_R_RDATA = 4'h4;
	localparam logic [3:0] FPC_R_PW0 = 4'h8; // passcode words at 8..b

	// ---------------------------------------------------------------
	// commands written to the command register
	// ---------------------------------------------------------------
	typedef enum logic [4:0] {
		FPC_OP_NONE = 5'h00, FPC_OP_ENT_PPB = 5'h01, FPC_OP_ENT_FRZ = 5'h02,
		FPC_OP_ENT_DYB = 5'h03, FPC_OP_ENT_LOCK = 5'h04, FPC_OP_ENT_PWD = 5'h05,
		FPC_OP_EXIT = 5'h06, FPC_OP_SETPROG = 5'h07, FPC_OP_PPB_ERASE = 5'h08,
		FPC_OP_PWD_UNLOCK = 5'h09, FPC_OP_READ = 5'h0a, FPC_OP_PWD_READ = 5'h0b,
		FPC_OP_A8_PROG = 5'h0c, FPC_OP_A8_AUTOSEL = 5'h0d, FPC_OP_A8_CHIPERS = 5'h0e,
		FPC_OP_A8_SECERS = 5'h0f, FPC_OP_SUSPEND = 5'h10, FPC_OP_RESUME = 5'h11,
		FPC_OP_RESET = 5'h12, FPC_OP_A8_BUFPROG = 5'h13, FPC_OP_BUF_WORD = 5'h14,
		FPC_OP_BUF_CONFIRM = 5'h15
	} fpc_op_t;

	localparam int FPC_SEQ_MAX = 8;
	localparam int FPC_CNT_W = 4;
	localparam int FPC_GAP_CYC = 2; // gap counter load; select stays idle 6 cycles between bus cycles

	// one flash bus cycle
	typedef struct packed {
		logic we;
		logic [25:0] addr;
		logic [15:0] data;
	} fpc_cyc_t;
endpackage

/* File: fpc_bus_cycle.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// one asynchronous flash bus cycle: setup, strobe, hold
// ---------------------------------------------------------------
module fpc_bus_cycle #(
	parameter int STROBE_CYC = 4
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// request
	input wire logic start_i,
	input fpc_pkg::fpc_cyc_t cyc_i,
	output logic busy_o,
	output logic done_o,
	output logic [15:0] rdata_o,
	// flash pins
	output logic cs_n_o,
	output logic we_n_o,
	output logic oe_n_o,
	output logic [25:0] addr_o,
	output logic [15:0] dq_o,
	output logic dq_oe_o,
	input wire logic [15:0] dq_i
);
	import fpc_pkg::*;
	typedef enum logic [3:0] {
		FPC_B_IDLE = 4'b0001, FPC_B_SET = 4'b0010, FPC_B_STB = 4'b0100, FPC_B_HOLD = 4'b1000
	} fpc_bst_t;
	fpc_bst_t st_ff;
	logic [7:0] cnt_ff;
	logic we_ff;

	// phase sequencer; address and write data set with select fall, read data taken on strobe rise
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			st_ff <= FPC_B_IDLE;
			cnt_ff <= 8'h00;
			we_ff <= 1'b0;
			cs_n_o <= 1'b1;
			we_n_o <= 1'b1;
			oe_n_o <= 1'b1;
			addr_o <= '0;
			dq_o <= '0;
			dq_oe_o <= 1'b0;
			rdata_o <= '0;
			done_o <= 1'b0;
		end else if (ce_i) begin
			done_o <= 1'b0;
			case (st_ff)
				FPC_B_IDLE: begin
					if (start_i) begin
						addr_o <= cyc_i.addr;
						dq_o <= cyc_i.data;
						dq_oe_o <= cyc_i.we;
						we_ff <= cyc_i.we;
						cs_n_o <= 1'b0;
						st_ff <= FPC_B_SET;
					end
				end
				FPC_B_SET: begin
					we_n_o <= ~we_ff;
					oe_n_o <= we_ff;
					cnt_ff <= 8'(STROBE_CYC);
					st_ff <= FPC_B_STB;
				end
				FPC_B_STB: begin
					if (cnt_ff == 8'h01) begin
						if (!we_ff)
							rdata_o <= dq_i;
						we_n_o <= 1'b1;
						oe_n_o <= 1'b1;
						st_ff <= FPC_B_HOLD;
					end else
						cnt_ff <= cnt_ff - 8'h01;
				end
				FPC_B_HOLD: begin
					cs_n_o <= 1'b1;
					dq_oe_o <= 1'b0;
					done_o <= 1'b1;
					st_ff <= FPC_B_IDLE;
				end
				default: st_ff <= FPC_B_IDLE;
			endcase
		end
	end

	assign busy_o = (st_ff != FPC_B_IDLE);
endmodule // fpc_bus_cycle

/* File: fpc_host_ctrl.sv */
`timescale 1ns/1ps
module fpc_host_ctrl #(
	parameter int STROBE_CYC = 4
) (
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// register port
	input wire logic [fpc_pkg::FPC_REG_AW-1:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// flash pins
	output logic flash_cs_n_o,
	output logic flash_we_n_o,
	output logic flash_oe_n_o,
	output logic [fpc_pkg::FPC_ADDR_W-1:0] flash_addr_o,
	output logic [fpc_pkg::FPC_DATA_W-1:0] flash_dq_o,
	output logic flash_dq_oe_o,
	input wire logic [fpc_pkg::FPC_DATA_W-1:0] flash_dq_i
);
	import fpc_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		FPC_S_IDLE = 4'b0001, FPC_S_ISSUE = 4'b0010, FPC_S_WAIT = 4'b0100,
		FPC_S_GAP = 4'b1000
	} fpc_st_t;
	fpc_st_t st_ff;
	logic [4:0] op_ff;
	logic [25:0] addr_ff;
	logic [15:0] data_ff;
	logic [15:0] pw_ff [4];
	logic [15:0] rdata_ff;
	logic [15:0] rd_hist_ff [4];
	logic [3:0] idx_ff;
	logic [3:0] len_ff;
	logic [1:0] gap_ff;
	logic err_ff;
	logic start;
	logic busy;
	logic done;
	logic [15:0] brd;
	fpc_cyc_t cur;
	logic [3:0] nxt_len;
	// state map in brief:
	// idle    waits for a command write; ADDR, DATA and passcode writes land here only
	// issue   loads the cycle count of the op and fires one bus cycle
	// wait    holds until the pin driver reports the cycle finished
	// gap     leaves the bus idle between cycles, then steps or returns to idle

	// ---------------------------------------------------------------
	// sector address: only top line down to A16 kept, low bits cleared
	// ---------------------------------------------------------------
	logic [25:0] sec_addr;
	assign sec_addr = {addr_ff[FPC_ADDR_W-1:FPC_SEC_LSB], 16'h0000};

	function automatic fpc_cyc_t wr(input logic [25:0] a, input logic [15:0] d);
		wr = '{we: 1'b1, addr: a, data: d};
	endfunction
	function automatic fpc_cyc_t rd(input logic [25:0] a);
		rd = '{we: 1'b0, addr: a, data: 16'h0000};
	endfunction
	// command byte on low lane, upper byte zero as don't care
	function automatic logic [15:0] cb(input logic [7:0] c);
		cb = {8'h00, c};
	endfunction

	// ---------------------------------------------------------------
	// sequence table: cycle idx of the current operation
	// ---------------------------------------------------------------
	always_comb begin
		cur = wr(FPC_A_ZERO, 16'h0000);
		nxt_len = 4'h1;
		case (op_ff)
			FPC_OP_ENT_PPB, FPC_OP_ENT_FRZ, FPC_OP_ENT_DYB,
			FPC_OP_ENT_LOCK, FPC_OP_ENT_PWD: begin
				nxt_len = 4'h3;
				case (idx_ff)
					4'h0: cur = wr(FPC_A16_UNLK1, cb(FPC_D_AA));
					4'h1: cur = wr(FPC_A16_UNLK2, cb(FPC_D_55));
					default: begin
						case (op_ff)
							FPC_OP_ENT_PPB: cur = wr(FPC_A16_UNLK1, cb(FPC_C_PPB));
							FPC_OP_ENT_FRZ: cur = wr(FPC_A16_UNLK1, cb(FPC_C_FREEZE));
							FPC_OP_ENT_DYB: cur = wr(FPC_A16_UNLK1, cb(FPC_C_DYB));
							FPC_OP_ENT_LOCK: cur = wr(FPC_A16_UNLK1, cb(FPC_C_LOCK));
							default: cur = wr(FPC_A16_UNLK1, cb(FPC_C_PWD));
						endcase
					end
				endcase
			end
			FPC_OP_EXIT: begin
				nxt_len = 4'h2;
				cur = (idx_ff == 4'h0) ? wr(addr_ff, cb(FPC_C_EXIT1)) :
					wr(addr_ff, cb(FPC_C_EXIT2));
			end
			FPC_OP_SETPROG: begin
				// lock word, passcode word, guard bits and freeze all use A0 then data
				nxt_len = 4'h2;
				cur = (idx_ff == 4'h0) ? wr(addr_ff, cb(FPC_C_PROG)) :
					wr(addr_ff, data_ff);
			end
			FPC_OP_PPB_ERASE: begin
				nxt_len = 4'h2;
				cur = (idx_ff == 4'h0) ? wr(FPC_A_ZERO, cb(FPC_C_ERASE)) :
					wr(FPC_A_ZERO, cb(FPC_C_ERS_SEC));
			end
			FPC_OP_PWD_UNLOCK: begin
				nxt_len = 4'h7;
				case (idx_ff)
					4'h0: cur = wr(FPC_A_ZERO, cb(FPC_C_UNL1));
					4'h1: cur = wr(FPC_A_ZERO, cb(FPC_C_UNL2));
					4'h6: cur = wr(FPC_A_ZERO, cb(FPC_C_CONFIRM));
					default: cur = wr(26'(idx_ff - 4'h2), pw_ff[2'(idx_ff - 4'h2)]);
				endcase
			end
			FPC_OP_READ: cur = rd(addr_ff);
			FPC_OP_PWD_READ: begin
				nxt_len = 4'h4;
				cur = rd(26'(idx_ff));
			end
			FPC_OP_A8_PROG, FPC_OP_A8_AUTOSEL, FPC_OP_A8_BUFPROG: begin
				nxt_len = (op_ff == FPC_OP_A8_PROG) ? 4'h4 :
					(op_ff == FPC_OP_A8_BUFPROG) ? 4'h4 : 4'h3;
				case (idx_ff)
					4'h0: cur = wr(FPC_A8_UNLK1, cb(FPC_D_AA));
					4'h1: cur = wr(FPC_A8_UNLK2, cb(FPC_D_55));
					4'h2: begin
						case (op_ff)
							FPC_OP_A8_PROG: cur = wr(FPC_A8_UNLK1, cb(FPC_C_PROG));
							FPC_OP_A8_AUTOSEL: cur = wr(FPC_A8_UNLK1, cb(FPC_C_AUTOSEL));
							default: cur = wr(sec_addr, cb(FPC_C_UNL1));
						endcase
					end
					default: begin
						if (op_ff == FPC_OP_A8_PROG)
							cur = wr(addr_ff, data_ff);
						else
							cur = wr(sec_addr, data_ff);
					end
				endcase
			end
			FPC_OP_BUF_WORD: cur = wr(addr_ff, data_ff);
			FPC_OP_BUF_CONFIRM: cur = wr(sec_addr, cb(FPC_C_CONFIRM));
			FPC_OP_A8_CHIPERS, FPC_OP_A8_SECERS: begin
				nxt_len = 4'h6;
				case (idx_ff)
					4'h0, 4'h3: cur = wr(FPC_A8_UNLK1, cb(FPC_D_AA));
					4'h1, 4'h4: cur = wr(FPC_A8_UNLK2, cb(FPC_D_55));
					4'h2: cur = wr(FPC_A8_UNLK1, cb(FPC_C_ERASE));
					default: cur = (op_ff == FPC_OP_A8_CHIPERS) ?
						wr(FPC_A8_UNLK1, cb(FPC_C_ERS_CHIP)) :
						wr(sec_addr, cb(FPC_C_ERS_SEC));
				endcase
			end
			FPC_OP_SUSPEND: cur = wr(addr_ff, cb(FPC_C_SUSPEND));
			FPC_OP_RESUME: cur = wr(addr_ff, cb(FPC_C_RESUME));
			FPC_OP_RESET: cur = wr(addr_ff, cb(FPC_C_RESET));
			default: cur = wr(FPC_A_ZERO, 16'h0000);
		endcase
	end

	// ---------------------------------------------------------------
	// command check: refuse a lock word with both mode bits programmed
	// ---------------------------------------------------------------
	// a program of the lock word that clears both mode lock bits at once
	// would be thrown away by the part and drop it back to array read,
	// leaving the command set half open; the controller never sends it
	// and raises the error flag instead, so software sees the refusal
	// the error flag clears on the next accepted command
	logic bad_lock;
	assign bad_lock = (reg_wdata_i[4:0] == 5'(FPC_OP_SETPROG)) &&
		(reg_addr_i == FPC_R_CMD) && !data_ff[FPC_LK_PERS] && !data_ff[FPC_LK_PWD] &&
		(addr_ff[7:0] == FPC_A_LOCKWORD[7:0]);

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	// one command becomes a fixed run of bus cycles taken from the table
	// above; the index walks the run and the gap keeps the strobes apart
	// commands that arrive while a run is in flight are ignored, so
	// software polls the busy bit before it writes the next one
	// the part has no ready line here: embedded algorithm time is left
	// to software, which must poll the part before the next program
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			st_ff <= FPC_S_IDLE;
			op_ff <= 5'(FPC_OP_NONE);
			idx_ff <= 4'h0;
			len_ff <= 4'h1;
			gap_ff <= 2'h0;
			err_ff <= 1'b0;
			start <= 1'b0;
		end else if (ce_i) begin
			start <= 1'b0;
			case (st_ff)
				FPC_S_IDLE: begin
					if (reg_wr_i && reg_addr_i == FPC_R_CMD) begin
						if (bad_lock)
							err_ff <= 1'b1;
						else if (reg_wdata_i[4:0] != 5'(FPC_OP_NONE)) begin
							err_ff <= 1'b0;
							op_ff <= reg_wdata_i[4:0];
							idx_ff <= 4'h0;
							st_ff <= FPC_S_ISSUE;
						end
					end
				end
				FPC_S_ISSUE: begin
					// fire only once the pin driver has gone back to idle
					if (!busy) begin
						len_ff <= nxt_len;
						start <= 1'b1;
						st_ff <= FPC_S_WAIT;
					end
				end
				FPC_S_WAIT: begin
					if (done) begin
						gap_ff <= 2'(FPC_GAP_CYC);
						st_ff <= FPC_S_GAP;
					end
				end
				FPC_S_GAP: begin
					if (gap_ff != 2'h0)
						gap_ff <= gap_ff - 2'h1;
					else if (idx_ff + 4'h1 >= len_ff) begin
						op_ff <= 5'(FPC_OP_NONE);
						st_ff <= FPC_S_IDLE;
					end else begin
						idx_ff <= idx_ff + 4'h1;
						st_ff <= FPC_S_ISSUE;
					end
				end
				default: st_ff <= FPC_S_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// software registers and read capture
	// ---------------------------------------------------------------
	// ADDR, DATA and the passcode words are frozen while a run is busy,
	// so the table never sees a half-updated operand in mid sequence
	// a single read lands in RDATA; a passcode read fills the read side
	// of the passcode slots, one word per bus cycle
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			addr_ff <= '0;
			data_ff <= '0;
			rdata_ff <= FPC_LOCK_RST;
			for (int i = 0; i < 4; i++) begin
				pw_ff[i] <= '0;
				rd_hist_ff[i] <= '0;
			end
		end else if (ce_i) begin
			if (reg_wr_i && st_ff == FPC_S_IDLE) begin
				case (reg_addr_i)
					FPC_R_ADDR: addr_ff <= reg_wdata_i[25:0];
					FPC_R_DATA: data_ff <= reg_wdata_i[15:0];
					default: begin
						if (reg_addr_i[3:2] == FPC_R_PW0[3:2])
							pw_ff[reg_addr_i[1:0]] <= reg_wdata_i[15:0];
					end
				endcase
			end
			if (done && op_ff == 5'(FPC_OP_READ))
				rdata_ff <= brd;
			if (done && op_ff == 5'(FPC_OP_PWD_READ))
				rd_hist_ff[idx_ff[1:0]] <= brd;
		end
	end

	// read data one cycle after the strobe
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			reg_rdata_o <= '0;
		else if (ce_i) begin
			reg_rdata_o <= '0;
			if (reg_rd_i) begin
				case (reg_addr_i)
					FPC_R_CMD: reg_rdata_o <= {27'h0, op_ff};
					FPC_R_ADDR: reg_rdata_o <= {6'h00, addr_ff};
					FPC_R_DATA: reg_rdata_o <= {16'h0000, data_ff};
					FPC_R_STAT: reg_rdata_o <= {30'h0, err_ff, st_ff != FPC_S_IDLE};
					FPC_R_RDATA: reg_rdata_o <= {16'h0000, rdata_ff};
					default: begin
						if (reg_addr_i[3:2] == FPC_R_PW0[3:2])
							reg_rdata_o <= {16'h0000, rd_hist_ff[reg_addr_i[1:0]]};
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// pin driver
	// ---------------------------------------------------------------
	// every pin comes from a flop inside the cycle module, so the part
	// sees clean select, strobe, address and data edges
	fpc_bus_cycle #(
		.STROBE_CYC(STROBE_CYC)
	) u_cyc (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.start_i(start),
		.cyc_i(cur),
		.busy_o(busy),
		.done_o(done),
		.rdata_o(brd),
		.cs_n_o(flash_cs_n_o),
		.we_n_o(flash_we_n_o),
		.oe_n_o(flash_oe_n_o),
		.addr_o(flash_addr_o),
		.dq_o(flash_dq_o),
		.dq_oe_o(flash_dq_oe_o),
		.dq_i(flash_dq_i)
	);
endmodule // fpc_host_ctrl

/* File: fpc_host_ctrl_sva.sv */
`timescale 1ns/1ps
module fpc_host_ctrl_chk #(
	parameter int STROBE_CYC = 4
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// register port
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	// flash pins
	input wire logic flash_cs_n_o,
	input wire logic flash_we_n_o,
	input wire logic flash_oe_n_o,
	input wire logic [25:0] flash_addr_o,
	input wire logic [15:0] flash_dq_o,
	input wire logic flash_dq_oe_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	logic [7:0] len_ff;
	// counts sampled strobe-low cycles of the current bus cycle
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || (flash_we_n_o && flash_oe_n_o))
			len_ff <= 8'h00;
		else
			len_ff <= len_ff + 8'h01;
	end
	property p_len; $rose(flash_we_n_o) || $rose(flash_oe_n_o) |-> len_ff == STROBE_CYC; endproperty
	a_len: assert property (p_len) else $error("strobe length wrong");
	property p_lead; $fell(flash_we_n_o) || $fell(flash_oe_n_o) |-> !$past(flash_cs_n_o); endproperty
	a_lead: assert property (p_lead) else $error("select does not lead strobe");
	property p_trail; $rose(flash_we_n_o) |-> !flash_cs_n_o ##1 flash_cs_n_o; endproperty
	a_trail: assert property (p_trail) else $error("select does not trail strobe");
	property p_hold;
		!flash_cs_n_o && !$fell(flash_cs_n_o) |-> $stable(flash_addr_o) && $stable(flash_dq_o);
	endproperty
	a_hold: assert property (p_hold) else $error("address or data moved in cycle");
	property p_gap; $rose(flash_cs_n_o) |-> flash_cs_n_o[*3]; endproperty
	a_gap: assert property (p_gap) else $error("idle gap too short");
	property p_sel; !flash_we_n_o || !flash_oe_n_o |-> !flash_cs_n_o && (flash_we_n_o || flash_oe_n_o);
	endproperty
	a_sel: assert property (p_sel) else $error("strobe without select or both strobes");
	property p_drv; !flash_we_n_o |-> flash_dq_oe_o; endproperty
	a_drv: assert property (p_drv) else $error("write without driving data");
	property p_rel; !flash_oe_n_o |-> !flash_dq_oe_o; endproperty
	a_rel: assert property (p_rel) else $error("read while driving data");
	property p_rdz; !$past(reg_rd_i) |-> reg_rdata_o == 32'h0; endproperty
	a_rdz: assert property (p_rdz) else $error("read data outside read slot");
	c_wr: cover property ($rose(flash_we_n_o));
	c_rd: cover property ($rose(flash_oe_n_o));
	c_reg: cover property (reg_rd_i ##1 reg_rdata_o != 32'h0);
endmodule // fpc_host_ctrl_chk
bind fpc_host_ctrl fpc_host_ctrl_chk #(.STROBE_CYC(STROBE_CYC)) i_chk (.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.flash_cs_n_o(flash_cs_n_o), .flash_we_n_o(flash_we_n_o), .flash_oe_n_o(flash_oe_n_o),
	.flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o));

/* File: fpc_flash_model.sv */
`timescale 1ns/1ps
module fpc_flash_model (
	// flash pins
	input wire logic cs_n_i,
	input wire logic we_n_i,
	input wire logic oe_n_i,
	input wire logic [25:0] addr_i,
	input wire logic [15:0] dq_i,
	output logic [15:0] dq_o
);
	logic [15:0] lock_ff = 16'hffff; // unprogrammed word reads all ones
	logic [7:0] c1 = 8'h00;
	logic [7:0] c2 = 8'h00;
	logic in_lock = 1'b0;
	logic [15:0] rd_val;
	logic [15:0] last = 16'h0000;
	// decode on strobe rise; command upper byte and high address ignored
	always @(posedge we_n_i) begin
		if (!cs_n_i) begin
			if (in_lock && c1 == 8'ha0) begin
				if (!dq_i[1] && !dq_i[2])
					in_lock = 1'b0; // both mode bits at once aborts
				else
					lock_ff = lock_ff & dq_i; // bits only go to 0
			end else if (c2 == 8'haa && c1 == 8'h55 && addr_i[15:0] == 16'h0555 && dq_i[7:0] == 8'h40)
				in_lock = 1'b1;
			else if ((c1 == 8'h90 && dq_i[7:0] == 8'h00) || dq_i[7:0] == 8'hf0)
				in_lock = 1'b0; // exit or reset to array read
			c2 = c1;
			c1 = dq_i[7:0];
		end
	end
	// lock word at 77h inside its set, array pattern elsewhere
	// no guard or identity table is kept: those reads show the array pattern
	assign rd_val = (in_lock && addr_i[7:0] == 8'h77) ? lock_ff : addr_i[15:0] ^ 16'h5a5a;
	// remember what was driven so a released bus shows its inverse
	always @(posedge oe_n_i) last = rd_val;
	assign dq_o = (!cs_n_i && !oe_n_i) ? rd_val : ~last;
endmodule // fpc_flash_model

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
	import fpc_pkg::*;
	localparam logic [25:0] DC = '1;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic cs_n, we_n, oe_n, dq_oe, we_q;
	logic [25:0] f_addr, a, sec;
	logic [15:0] f_dq, m_dq, dq_wire, d;
	logic [15:0] pw[4];
	logic [31:0] v;
	logic [25:0] ea[$], sa[$];
	logic [15:0] ed[$], sd[$];
	int n_errors = 0;
	int checks_done = 0;
	fpc_op_t eo[5] = '{FPC_OP_ENT_PPB, FPC_OP_ENT_FRZ, FPC_OP_ENT_DYB, FPC_OP_ENT_LOCK, FPC_OP_ENT_PWD};
	logic [7:0] cb[5] = '{FPC_C_PPB, FPC_C_FREEZE, FPC_C_DYB, FPC_C_LOCK, FPC_C_PWD};
	fpc_op_t so[3] = '{FPC_OP_SUSPEND, FPC_OP_RESUME, FPC_OP_RESET};
	logic [7:0] sc[3] = '{FPC_C_SUSPEND, FPC_C_RESUME, FPC_C_RESET};
	initial forever #4 clk_sys_i = ~clk_sys_i;
	assign dq_wire = dq_oe ? f_dq : m_dq;
	fpc_host_ctrl i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_rdata_o(reg_rdata), .flash_cs_n_o(cs_n), .flash_we_n_o(we_n), .flash_oe_n_o(oe_n),
		.flash_addr_o(f_addr), .flash_dq_o(f_dq), .flash_dq_oe_o(dq_oe), .flash_dq_i(dq_wire));
	fpc_flash_model i_flash (.cs_n_i(cs_n), .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(f_addr),
		.dq_i(dq_wire), .dq_o(m_dq));
	// log each flash write cycle once its strobe has risen
	always @(posedge clk_sys_i) begin
		we_q <= we_n;
		if (rst_n_i && we_n && !we_q && !cs_n) begin
			sa.push_back(f_addr);
			sd.push_back(f_dq);
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] ad, input logic [31:0] da);
		@(posedge clk_sys_i);
		reg_addr <= ad;
		reg_wdata <= da;
		reg_wr <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] ad, output logic [31:0] da);
		@(posedge clk_sys_i);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd <= 1'b0;
		#1 da = reg_rdata;
	endtask
	task automatic ex(input logic [25:0] ad, input logic [15:0] da);
		ea.push_back(ad);
		ed.push_back(da);
	endtask
	task automatic ex8(input logic [25:0] ad, input logic [7:0] da);
		ex(ad, {8'h00, da});
	endtask
	task automatic u8();
		ex8(FPC_A8_UNLK1, FPC_D_AA);
		ex8(FPC_A8_UNLK2, FPC_D_55);
	endtask
	// issue one op, wait for idle, compare the logged writes
	task automatic run(input fpc_op_t op);
		int i;
		logic [31:0] s;
		wr(FPC_R_CMD, {27'h0, op});
		i = 0;
		do begin
			rd(FPC_R_STAT, s);
			i++;
		end while (s[0] !== 1'b0 && i < 500);
		chk({31'h0, s[0]}, 32'h0);
		chk(32'(sa.size()), 32'(ea.size()));
		for (i = 0; i < ea.size() && i < sa.size(); i++) begin
			if (ea[i] !== DC)
				chk({6'h0, sa[i]}, {6'h0, ea[i]});
			chk({16'h0, sd[i]}, {16'h0, ed[i]});
		end
		ea.delete();
		ed.delete();
		sa.delete();
		sd.delete();
	endtask
	task automatic finish_test();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// cut a hang short
	initial begin
		#400000;
		n_errors++;
		finish_test();
	end
	// main sequence
	initial begin
		void'($urandom(32'hd167fd1d));
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		wr(4'h5, $urandom);
		rd(FPC_R_STAT, v);
		chk(v, 32'h0);
		rd(FPC_R_RDATA, v);
		chk(v, 32'h0000ffff);
		for (int k = 0; k < 5; k++) begin
			ex8(FPC_A16_UNLK1, FPC_D_AA);
			ex8(FPC_A16_UNLK2, FPC_D_55);
			ex8(FPC_A16_UNLK1, cb[k]);
			run(eo[k]);
			a = (k == 3) ? FPC_A_LOCKWORD : (k == 4) ? 26'($urandom % 4) : {10'($urandom), 16'h0};
			d = (k >= 3) ? (16'($urandom) | 16'h0002) : (k == 2) ? 16'($urandom % 2) : 16'h0;
			wr(FPC_R_ADDR, {6'h0, a});
			wr(FPC_R_DATA, {16'h0, d});
			ex8(DC, FPC_C_PROG);
			ex(a, d);
			run(FPC_OP_SETPROG);
			if (k == 3) begin
				run(FPC_OP_READ);
				rd(FPC_R_RDATA, v);
				chk(v, {16'h0, d});
				wr(FPC_R_DATA, 32'h0000fff9);
				run(FPC_OP_SETPROG);
				rd(FPC_R_STAT, v);
				chk({31'h0, v[1]}, 32'h1);
			end
			a = 26'($urandom);
			wr(FPC_R_ADDR, {6'h0, a});
			ex8(a, FPC_C_EXIT1);
			ex8(a, FPC_C_EXIT2);
			run(FPC_OP_EXIT);
		end
		for (int i = 0; i < 4; i++) begin
			pw[i] = 16'($urandom);
			wr(FPC_R_PW0 + 4'(i), {16'h0, pw[i]});
		end
		ex8(FPC_A_ZERO, FPC_C_UNL1);
		ex8(FPC_A_ZERO, FPC_C_UNL2);
		for (int i = 0; i < 4; i++)
			ex(26'(i), pw[i]);
		ex8(FPC_A_ZERO, FPC_C_CONFIRM);
		run(FPC_OP_PWD_UNLOCK);
		run(FPC_OP_PWD_READ);
		for (int i = 0; i < 4; i++) begin
			rd(FPC_R_PW0 + 4'(i), v);
			chk(v, {16'h0, 16'(i) ^ 16'h5a5a});
		end
		ex8(DC, FPC_C_ERASE);
		ex8(FPC_A_ZERO, FPC_C_ERS_SEC);
		run(FPC_OP_PPB_ERASE);
		a = 26'($urandom);
		d = 16'($urandom);
		sec = {a[25:16], 16'h0};
		wr(FPC_R_ADDR, {6'h0, a});
		wr(FPC_R_DATA, {16'h0, d});
		u8();
		ex8(FPC_A8_UNLK1, FPC_C_PROG);
		ex(a, d);
		run(FPC_OP_A8_PROG);
		u8();
		ex8(FPC_A8_UNLK1, FPC_C_AUTOSEL);
		run(FPC_OP_A8_AUTOSEL);
		for (int k = 0; k < 2; k++) begin
			u8();
			ex8(FPC_A8_UNLK1, FPC_C_ERASE);
			u8();
			ex8(k ? sec : FPC_A8_UNLK1, k ? FPC_C_ERS_SEC : FPC_C_ERS_CHIP);
			run(k ? FPC_OP_A8_SECERS : FPC_OP_A8_CHIPERS);
		end
		d = 16'($urandom % 16);
		wr(FPC_R_DATA, {16'h0, d});
		u8();
		ex8(sec, FPC_C_UNL1);
		ex(sec, d);
		run(FPC_OP_A8_BUFPROG);
		d = 16'($urandom);
		wr(FPC_R_DATA, {16'h0, d});
		ex(a, d);
		run(FPC_OP_BUF_WORD);
		ex8(sec, FPC_C_CONFIRM);
		run(FPC_OP_BUF_CONFIRM);
		for (int k = 0; k < 3; k++) begin
			ex8(DC, sc[k]);
			run(so[k]);
		end
		finish_test();
	end
endmodule // tb
